// >>> erc_params.svh
`ifndef ERC_PARAMS_SVH
`define ERC_PARAMS_SVH

// Register offsets.
`define ERC_MAG_OFFSET 2'h2
`define ERC_ROUTE_OFFSET 2'h3

// Field positions of the routing register.
`define ERC_FIRST_MSB 7
`define ERC_FIRST_LSB 5
`define ERC_SECOND_MSB 4
`define ERC_SECOND_LSB 2

// Reset values.
`define ERC_ROUTE_RESET 3'h0
`define ERC_MAG_RESET 3'h0

// Route codes.
`define ERC_ROUTE_OFF 3'h0
`define ERC_ROUTE_REFERENCE_POS_PIN 3'h5
`define ERC_ROUTE_REFERENCE_NEG_PIN 3'h6
`define ERC_ROUTE_RSVD 3'h7

// Fixed upper bits of the target address; the straps fill the low four.
`define ERC_ADDR_BASE 3'h4

// Bits per byte on the serial bus.
`define ERC_BYTE_BITS 4'h8

`endif

// >>> erc_pkg.sv
package erc_pkg;

    typedef enum logic [3:0] {
        ERC_IDLE = 4'b0000,
        ERC_ADDR = 4'b0001,
        ERC_AACK = 4'b0010,
        ERC_PTR = 4'b0011,
        ERC_WACK = 4'b0100,
        ERC_WDATA = 4'b0101,
        ERC_RDATA = 4'b0110,
        ERC_RACK = 4'b0111
    } erc_state_t;

    typedef struct packed {
        erc_state_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] tx;
        logic rw;
        logic [1:0] ptr;
        logic [2:0] route1;
        logic [2:0] route2;
        logic [2:0] mag;
        logic sda_oe_n;
        logic scl_q;
        logic sda_q;
        logic strap_done;
        logic [6:0] addr;
        logic ready;
    } erc_regs_t;

    typedef struct packed {
        logic [5:0] pin_en;
    } erc_dec_t;

endpackage : erc_pkg

// >>> erc_route_dec.sv
`timescale 1ns/1ps
`include "erc_params.svh"

// Turns one route code into a registered one-hot pin enable:
// bit 0..3 analog inputs zero..three, bit 4 positive and bit 5 negative reference pin.
module erc_route_dec (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] code,
    input wire logic enable,
    output logic [5:0] pin_en
);
    import erc_pkg::*;

    erc_dec_t s_q;
    erc_dec_t s_d;

    // The reserved code connects nothing, which keeps an undefined setting harmless.
    always_comb begin
        s_d.pin_en = 6'h00;
        if (enable && code != `ERC_ROUTE_OFF && code != `ERC_ROUTE_RSVD) begin
            s_d.pin_en[code - 3'h1] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pin_en = s_q.pin_en;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    route_reference_pos_pin_a: assert property (enable && code == `ERC_ROUTE_REFERENCE_POS_PIN |=> pin_en == 6'h10)
        else $error("Code five does not select the positive reference pin.");
    route_reference_neg_pin_a: assert property (enable && code == `ERC_ROUTE_REFERENCE_NEG_PIN |=> pin_en == 6'h20)
        else $error("Code six does not select the negative reference pin.");
    route_off_a: assert property (code == `ERC_ROUTE_OFF || !enable |=> pin_en == 6'h00)
        else $error("A source is connected while disabled.");
    route_onehot_a: assert property ($onehot0(pin_en))
        else $error("A source is routed to more than one pin.");

endmodule : erc_route_dec

// >>> erc_regs.sv
`timescale 1ns/1ps
`include "erc_params.svh"

module erc_regs (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl_in,
    output logic scl_oe_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [1:0] addr_strap_low,
    input wire logic [1:0] addr_strap_high,
    input wire logic conv_done,
    output logic conversion_ready_out,
    output logic conversion_ready_out_oe_n,
    output logic [2:0] first_current_route,
    output logic [2:0] second_current_route,
    output logic [2:0] excitation_magnitude,
    output logic [5:0] first_excitation_source,
    output logic [5:0] second_excitation_source
);
    import erc_pkg::*;

    erc_regs_t s_q;
    erc_regs_t s_d;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic byte_end;
    logic addr_hit;
    logic rd_match;
    logic [7:0] rdval;

    // Bus edges are found against the previous sample; all logic runs far above bus rate.
    assign rise = scl_in & ~s_q.scl_q;
    assign fall = ~scl_in & s_q.scl_q;
    assign start = s_q.scl_q & scl_in & s_q.sda_q & ~sda_in;
    assign stop = s_q.scl_q & scl_in & ~s_q.sda_q & sda_in;
    assign byte_end = fall && s_q.cnt == `ERC_BYTE_BITS;
    assign addr_hit = s_q.st == ERC_ADDR && byte_end && s_q.sh[7:1] == s_q.addr;
    assign rd_match = addr_hit && s_q.sh[0];

    // Read data; the low two bits of the routing register are always zero.
    always_comb begin
        rdval = 8'h00;
        if (s_q.ptr == `ERC_ROUTE_OFFSET) begin
            rdval = {s_q.route1, s_q.route2, 2'b00};
        end else if (s_q.ptr == `ERC_MAG_OFFSET) begin
            rdval = {5'h00, s_q.mag};
        end
    end

    // Serial target state machine and register writes.
    always_comb begin
        s_d = s_q;
        s_d.scl_q = scl_in;
        s_d.sda_q = sda_in;
        // The straps are caught once, in the first cycle after reset release.
        if (!s_q.strap_done) begin
            s_d.addr = {`ERC_ADDR_BASE, addr_strap_high, addr_strap_low};
            s_d.strap_done = 1'b1;
        end
        // A conversion that finishes during an addressed read is not lost.
        if (rd_match) begin
            s_d.ready = 1'b0;
        end
        if (conv_done) begin
            s_d.ready = 1'b1;
        end
        if (start) begin
            s_d.st = ERC_ADDR;
            s_d.cnt = 4'h0;
            s_d.sda_oe_n = 1'b1;
        end else if (stop) begin
            s_d.st = ERC_IDLE;
            s_d.sda_oe_n = 1'b1;
        end else begin
            unique case (s_q.st)
                ERC_IDLE: begin
                end
                ERC_ADDR, ERC_PTR, ERC_WDATA: begin
                    if (rise) begin
                        s_d.sh = {s_q.sh[6:0], sda_in};
                        s_d.cnt = s_q.cnt + 4'h1;
                    end else if (byte_end) begin
                        s_d.sda_oe_n = 1'b0;
                        s_d.st = ERC_WACK;
                        if (s_q.st == ERC_ADDR) begin
                            s_d.rw = s_q.sh[0];
                            s_d.st = addr_hit ? ERC_AACK : ERC_IDLE;
                            s_d.sda_oe_n = ~addr_hit;
                        end else if (s_q.st == ERC_PTR) begin
                            s_d.ptr = s_q.sh[1:0];
                        end else if (s_q.ptr == `ERC_ROUTE_OFFSET) begin
                            // Bits 1:0 are dropped; they hold no storage.
                            s_d.route1 = s_q.sh[`ERC_FIRST_MSB:`ERC_FIRST_LSB];
                            s_d.route2 = s_q.sh[`ERC_SECOND_MSB:`ERC_SECOND_LSB];
                        end else if (s_q.ptr == `ERC_MAG_OFFSET) begin
                            s_d.mag = s_q.sh[2:0];
                        end
                    end
                end
                ERC_AACK: begin
                    if (fall) begin
                        s_d.cnt = 4'h0;
                        if (s_q.rw) begin
                            s_d.tx = {rdval[6:0], 1'b0};
                            s_d.sda_oe_n = rdval[7];
                            s_d.st = ERC_RDATA;
                        end else begin
                            s_d.sda_oe_n = 1'b1;
                            s_d.st = ERC_PTR;
                        end
                    end
                end
                ERC_WACK: begin
                    if (fall) begin
                        s_d.sda_oe_n = 1'b1;
                        s_d.cnt = 4'h0;
                        s_d.st = ERC_WDATA;
                    end
                end
                ERC_RDATA: begin
                    if (rise) begin
                        s_d.cnt = s_q.cnt + 4'h1;
                    end else if (byte_end) begin
                        s_d.sda_oe_n = 1'b1;
                        s_d.st = ERC_RACK;
                    end else if (fall) begin
                        s_d.sda_oe_n = s_q.tx[7];
                        s_d.tx = {s_q.tx[6:0], 1'b0};
                    end
                end
                ERC_RACK: begin
                    // A not-acknowledge from the host ends the read.
                    if (rise && sda_in) begin
                        s_d.st = ERC_IDLE;
                    end else if (fall) begin
                        s_d.cnt = 4'h0;
                        s_d.tx = {rdval[6:0], 1'b0};
                        s_d.sda_oe_n = rdval[7];
                        s_d.st = ERC_RDATA;
                    end
                end
                default: begin
                    s_d.st = ERC_IDLE;
                    s_d.sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    // Every field but sda_oe_n, scl_q and sda_q clears to zero, so both sources start disconnected.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
            s_q.sda_oe_n <= 1'b1;
            s_q.scl_q <= 1'b1;
            s_q.sda_q <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // The clock line is only ever read, so no stretching is possible.
    assign scl_oe_n = 1'b1;
    assign sda_out = 1'b0;
    assign sda_oe_n = s_q.sda_oe_n;
    // Open-drain: the pin is only pulled low while a result waits.
    assign conversion_ready_out = 1'b0;
    assign conversion_ready_out_oe_n = ~s_q.ready;
    assign first_current_route = s_q.route1;
    assign second_current_route = s_q.route2;
    assign excitation_magnitude = s_q.mag;

    // Magnitude zero turns both sources off, whatever the routes say.
    erc_route_dec u_first (
        .clk(clk),
        .nrst(nrst),
        .code(s_q.route1),
        .enable(s_q.mag != `ERC_MAG_RESET),
        .pin_en(first_excitation_source)
    );

    erc_route_dec u_second (
        .clk(clk),
        .nrst(nrst),
        .code(s_q.route2),
        .enable(s_q.mag != `ERC_MAG_RESET),
        .pin_en(second_excitation_source)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    scl_release_a: assert property (scl_oe_n)
        else $error("The clock line is being driven.");
    ready_drain_a: assert property (conv_done |=> !conversion_ready_out_oe_n)
        else $error("Ready output not pulled low after a conversion.");
    ready_value_a: assert property (conversion_ready_out == 1'b0)
        else $error("Ready output drives a high level.");
    addr_ack_a: assert property (addr_hit |=> !sda_oe_n && s_q.st == ERC_AACK)
        else $error("Matching address not acknowledged.");
    ack_hold_a: assert property (s_q.st == ERC_AACK |-> !sda_oe_n)
        else $error("Address acknowledge released before the bit ends.");
    addr_miss_a: assert property (s_q.st == ERC_ADDR && byte_end && !addr_hit |=> sda_oe_n && s_q.st == ERC_IDLE)
        else $error("Foreign address was acknowledged.");
    route_write_a: assert property (s_q.st == ERC_WDATA && byte_end && s_q.ptr == `ERC_ROUTE_OFFSET
        |=> first_current_route == $past(s_q.sh[7:5]) && second_current_route == $past(s_q.sh[4:2]))
        else $error("Routing register write not taken.");
    rsvd_zero_a: assert property (s_q.st == ERC_AACK && fall && s_q.rw && s_q.ptr == `ERC_ROUTE_OFFSET
        |=> s_q.tx[2:1] == 2'b00)
        else $error("Reserved routing bits do not read as zero.");
    mag_write_a: assert property (s_q.st == ERC_WDATA && byte_end && s_q.ptr == `ERC_MAG_OFFSET
        |=> excitation_magnitude == $past(s_q.sh[2:0]))
        else $error("Magnitude write not taken.");
    route_reset_a: assert property ($rose(s_q.strap_done) |-> first_current_route == 3'h0
        && second_current_route == 3'h0 && excitation_magnitude == 3'h0)
        else $error("Routes not disconnected after reset.");
    byte_ack_a: assert property (s_q.st == ERC_WDATA && byte_end |=> !sda_oe_n && s_q.st == ERC_WACK)
        else $error("Written byte not acknowledged.");

    write_route_c: cover property (s_q.st == ERC_WDATA && byte_end && s_q.ptr == `ERC_ROUTE_OFFSET);
    read_route_c: cover property (s_q.st == ERC_RDATA && byte_end && s_q.ptr == `ERC_ROUTE_OFFSET);
    ready_clear_c: cover property (!conversion_ready_out_oe_n ##1 rd_match);

endmodule : erc_regs

// >>> erc_host.sv
`timescale 1ns/1ps
// Bus controller model: it only pulls lines low and never waits on a held clock.
module erc_host (
    input wire logic clk,
    input wire logic scl_line,
    input wire logic sda_line,
    output logic scl_oe_n,
    output logic sda_oe_n
);
    localparam int HALF = 4;
    // Both lines start released so the pull-ups hold them idle high.
    initial begin
        scl_oe_n = 1'b1;
        sda_oe_n = 1'b1;
    end
    task automatic gap;
        repeat (HALF) @(negedge clk);
    endtask : gap
    // Master-only timing: the clock is released blindly, as no target stretches it.
    task automatic bit_io(input logic b, output logic r);
        sda_oe_n = b;
        gap();
        scl_oe_n = 1'b1;
        gap();
        r = sda_line;
        scl_oe_n = 1'b0;
        gap();
    endtask : bit_io
    // Data is let go before the clock rises, so a repeated start is never read as a stop.
    task automatic start;
        sda_oe_n = 1'b1;
        gap();
        scl_oe_n = 1'b1;
        gap();
        sda_oe_n = 1'b0;
        gap();
        scl_oe_n = 1'b0;
        gap();
    endtask : start
    task automatic stop;
        sda_oe_n = 1'b0;
        gap();
        scl_oe_n = 1'b1;
        gap();
        sda_oe_n = 1'b1;
        gap();
    endtask : stop
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask : wr_byte
    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(nack, r);
    endtask : rd_byte
endmodule : erc_host

// >>> tb_erc_regs.sv
`timescale 1ns/1ps
`include "erc_params.svh"
module tb_erc_regs;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic conv_done = 1'b0;
    logic [3:0] strap = 4'h0;
    logic scl_oe_n, sda_oe_n, sda_out, h_scl_oe_n, h_sda_oe_n, rdy, rdy_oe_n, a;
    logic [2:0] r1, r2, mag;
    logic [5:0] p1, p2;
    logic [7:0] d;
    wire logic scl_line = h_scl_oe_n & scl_oe_n;
    wire logic sda_line = h_sda_oe_n & (sda_oe_n | sda_out);
    int n_fail = 0;
    int checks = 0;
    // Clock at 200 MHz.
    initial begin
        forever #2.5 clk = ~clk;
    end
    erc_regs i_dut (.clk(clk), .nrst(nrst), .scl_in(scl_line), .scl_oe_n(scl_oe_n),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .addr_strap_low(strap[1:0]), .addr_strap_high(strap[3:2]), .conv_done(conv_done),
        .conversion_ready_out(rdy), .conversion_ready_out_oe_n(rdy_oe_n),
        .first_current_route(r1), .second_current_route(r2), .excitation_magnitude(mag),
        .first_excitation_source(p1), .second_excitation_source(p2));
    erc_host i_host (.clk(clk), .scl_line(scl_line), .sda_line(sda_line),
        .scl_oe_n(h_scl_oe_n), .sda_oe_n(h_sda_oe_n));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s saw %h want %h", $time, what, seen, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    // Straps are caught just after release, so they are set while reset is held.
    task automatic do_reset(input logic [3:0] s);
        nrst = 1'b0;
        strap = s;
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
    endtask : do_reset
    function automatic logic [7:0] adr(input logic rd);
        return {`ERC_ADDR_BASE, strap, rd};
    endfunction : adr
    function automatic logic [5:0] pins(input logic [2:0] c);
        if (c >= 3'h1 && c <= 3'h6) begin
            return 6'h01 << (c - 3'h1);
        end
        return 6'h00;
    endfunction : pins
    task automatic reg_write(input logic [1:0] ptr, input logic [7:0] v);
        i_host.start();
        i_host.wr_byte(adr(1'b0), a);
        i_host.wr_byte({6'h00, ptr}, a);
        i_host.wr_byte(v, a);
        chk({7'h00, a}, 8'h01, "data ack");
        i_host.stop();
    endtask : reg_write
    task automatic reg_read(input logic [1:0] ptr);
        i_host.start();
        i_host.wr_byte(adr(1'b0), a);
        i_host.wr_byte({6'h00, ptr}, a);
        i_host.start();
        i_host.wr_byte(adr(1'b1), a);
        i_host.rd_byte(1'b1, d);
        i_host.stop();
    endtask : reg_read
    task automatic t_reset_vals;
        chk({r1, r2}, 8'h00, "routes");
        chk({p1, mag[1:0]}, 8'h00, "pins");
        chk({p2, scl_oe_n, rdy_oe_n}, 8'h03, "idle");
        reg_read(2'h3);
        chk(d, 8'h00, "route reg");
        $display("reset values done");
    endtask : t_reset_vals
    // Every legal code on both fields, the second running opposite to the first.
    task automatic t_codes;
        reg_write(2'h2, 8'h03);
        chk({5'h00, mag}, 8'h03, "magnitude");
        reg_read(2'h2);
        chk(d, 8'h03, "magnitude readback");
        for (int c = 0; c < 7; c++) begin
            reg_write(2'h3, {c[2:0], 3'h6 - c[2:0], 2'h0});
            @(negedge clk);
            chk({5'h00, r1}, {5'h00, c[2:0]}, "first");
            chk({5'h00, r2}, {5'h00, 3'h6 - c[2:0]}, "second");
            chk({2'h0, p1}, {2'h0, pins(c[2:0])}, "first pins");
            chk({2'h0, p2}, {2'h0, pins(3'h6 - c[2:0])}, "second pins");
            reg_read(2'h3);
            chk(d, {c[2:0], 3'h6 - c[2:0], 2'h0}, "readback");
        end
        $display("route codes done");
    endtask : t_codes
    // The host keeps its duty and writes zeros low; the low bits must read back zero.
    task automatic t_low_bits;
        reg_write(2'h3, 8'hA4);
        reg_read(2'h3);
        chk(d, 8'hA4, "low bits");
        reg_write(2'h2, 8'h00);
        @(negedge clk);
        chk({p1, 2'h0}, 8'h00, "off magnitude");
        chk({5'h00, r1}, 8'h05, "kept route");
        $display("low bits done");
    endtask : t_low_bits
    task automatic t_ready;
        conv_done = 1'b1;
        @(negedge clk);
        conv_done = 1'b0;
        @(negedge clk);
        chk({6'h00, rdy, rdy_oe_n}, 8'h00, "ready low");
        reg_read(2'h3);
        chk({7'h00, rdy_oe_n}, 8'h01, "ready released");
        $display("ready pin done");
    endtask : t_ready
    task automatic t_addr;
        for (int s = 0; s < 16; s++) begin
            do_reset(s[3:0]);
            i_host.start();
            i_host.wr_byte(adr(1'b0), a);
            chk({7'h00, a}, 8'h01, "own address");
            i_host.stop();
            i_host.start();
            i_host.wr_byte(adr(1'b0) ^ 8'h02, a);
            chk({6'h00, a, scl_oe_n}, 8'h01, "other address");
            i_host.stop();
        end
        $display("addresses done");
    endtask : t_addr
    // Main sequence.
    initial begin
        do_reset(4'h9);
        t_reset_vals();
        t_codes();
        t_low_bits();
        t_ready();
        t_addr();
        end_sim();
    end
    // Watchdog against a hang.
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        end_sim();
    end
endmodule : tb_erc_regs
